/* File: sbia_bridge.sv */
`timescale 1ns/1ps
module sbia_bridge (
   input  wire logic                           ref_clk_in,
   input  wire logic                           sys_rst_in,
   input  wire logic [sbia_pkg::SBIA_IDX_W-1:0] host_addr_in,
   input  wire logic [31:0]                    host_wdata_in,
   input  wire logic                           host_wr_in,
   input  wire logic                           host_rd_in,
   output logic      [31:0]                    host_rdata_out,
   output logic                                sb_req_out,
   output logic                                sb_we_out,
   output logic      [31:0]                    sb_addr_out,
   output logic      [31:0]                    sb_wdata_out,
   input  wire logic [31:0]                    sb_rdata_in,
   input  wire logic                           sb_ack_in,
   input  wire logic                           sb_err_in,
   output logic                                irq_out
);
   import sbia_pkg::*;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   logic is_stat, is_addr, is_data, is_incr, is_inrt, is_ist, is_imsk;
   logic port_hit, pending, start;
   logic m_done, m_err, m_read;
   logic [31:0] m_rdata;

   // host port decode and access start
   always_comb begin
      is_stat  = (host_addr_in == SBIA_IDX_STAT);
      is_addr  = (host_addr_in == SBIA_IDX_ADDR);
      is_data  = (host_addr_in == SBIA_IDX_DATA);
      is_incr  = (host_addr_in == SBIA_IDX_INCR);
      is_inrt  = (host_addr_in == SBIA_IDX_INRT);
      is_ist   = (host_addr_in == SBIA_IDX_IST);
      is_imsk  = (host_addr_in == SBIA_IDX_IMSK);
      port_hit = is_data | is_incr | is_inrt;
      // passive port never starts; busy accesses are refused
      start    = (host_wr_in | host_rd_in) & (is_data | is_incr) & ~pending; // R05 R13
   end

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic [31:0]           taddr_r, taddr_nxt;
   logic [31:0]           tdata_r, tdata_nxt;
   logic [31:0]           rdata_r, rdata_nxt;
   logic                  err_r, err_nxt;
   logic                  lrpnd_r, lrpnd_nxt;
   logic                  lrerr_r, lrerr_nxt;
   logic [SBIA_IRQ_W-1:0] ist_r, ist_nxt;
   logic [SBIA_IRQ_W-1:0] imsk_r, imsk_nxt;
   logic [SBIA_IRQ_W-1:0] evt;

   // next values of every register
   always_comb begin
      taddr_nxt = taddr_r;
      tdata_nxt = tdata_r;
      err_nxt   = err_r;
      lrpnd_nxt = lrpnd_r;
      lrerr_nxt = lrerr_r;
      imsk_nxt  = imsk_r;
      ist_nxt   = ist_r;
      rdata_nxt = SBIA_RST_WORD;

      // target address: host load, or step after an autoinc start
      if (host_wr_in && is_addr) begin
         taddr_nxt = host_wdata_in;
      end else if (start && is_incr) begin
         taddr_nxt = taddr_r + SBIA_STEP; // R04
      end

      // transfer data: bus result wins over a passive write
      if (m_done) begin
         if (m_err) begin
            tdata_nxt = SBIA_MARKER; // R06
         end else if (m_read) begin
            tdata_nxt = m_rdata; // R03
         end
      end else if (host_wr_in && port_hit && (is_inrt || !pending)) begin
         tdata_nxt = host_wdata_in; // R02 R04 R05
      end

      // error flag clears by writing one; a new error wins
      if (host_wr_in && is_stat && host_wdata_in[SBIA_ST_ERR]) begin
         err_nxt = 1'b0;
      end
      if (m_done && m_err) begin
         err_nxt = 1'b1; // R06 R07
      end

      // snapshot of pending and error at each data read
      if (host_rd_in && port_hit) begin
         lrpnd_nxt = pending; // R09
         lrerr_nxt = err_r;
      end

      if (host_wr_in && is_imsk) begin
         imsk_nxt = host_wdata_in[SBIA_IRQ_W-1:0];
      end

      // sticky events; read clears but a same-cycle event survives
      if (host_rd_in && is_ist) begin
         ist_nxt = SBIA_RST_IRQ;
      end
      ist_nxt = ist_nxt | evt;

      // read data stands one cycle after the read strobe
      if (host_rd_in) begin
         case (host_addr_in)
            SBIA_IDX_STAT: begin
               rdata_nxt[SBIA_ST_PEND]  = pending; // R09
               rdata_nxt[SBIA_ST_LRPND] = lrpnd_r;
               rdata_nxt[SBIA_ST_ERR]   = err_r;
               rdata_nxt[SBIA_ST_LRERR] = lrerr_r;
            end
            SBIA_IDX_ADDR: rdata_nxt = taddr_r;
            SBIA_IDX_DATA,
            SBIA_IDX_INCR,
            SBIA_IDX_INRT: rdata_nxt = pending ? SBIA_MARKER : tdata_r; // R08
            SBIA_IDX_IST:  rdata_nxt[SBIA_IRQ_W-1:0] = ist_r;
            SBIA_IDX_IMSK: rdata_nxt[SBIA_IRQ_W-1:0] = imsk_r;
            default:       rdata_nxt = SBIA_RST_WORD;
         endcase
      end
   end

   // events raised by the bus master
   always_comb begin
      evt                = SBIA_RST_IRQ;
      evt[SBIA_IRQ_DONE] = m_done;
      evt[SBIA_IRQ_ERR]  = m_done & m_err;
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         taddr_r <= SBIA_RST_WORD;
         tdata_r <= SBIA_RST_WORD;
         rdata_r <= SBIA_RST_WORD;
         err_r   <= 1'b0;
         lrpnd_r <= 1'b0;
         lrerr_r <= 1'b0;
         ist_r   <= SBIA_RST_IRQ;
         imsk_r  <= SBIA_RST_IRQ;
      end else begin
         taddr_r <= taddr_nxt;
         tdata_r <= tdata_nxt;
         rdata_r <= rdata_nxt;
         err_r   <= err_nxt;
         lrpnd_r <= lrpnd_nxt;
         lrerr_r <= lrerr_nxt;
         ist_r   <= ist_nxt;
         imsk_r  <= imsk_nxt;
      end
   end

   assign host_rdata_out = rdata_r;
   assign irq_out        = |(ist_r & imsk_r);

   // ---------------------------------------------------------------
   // dedicated shared bus master
   // ---------------------------------------------------------------
   // write data comes straight from the host so the word is not one cycle late
   sbia_master u_master (
      .ref_clk_in   (ref_clk_in),
      .sys_rst_in   (sys_rst_in),
      .start_in     (start),
      .we_in        (host_wr_in),
      .addr_in      (taddr_r),
      .wdata_in     (host_wdata_in),
      .busy_out     (pending),
      .done_out     (m_done),
      .err_out      (m_err),
      .read_out     (m_read),
      .rdata_out    (m_rdata),
      .sb_req_out   (sb_req_out),
      .sb_we_out    (sb_we_out),
      .sb_addr_out  (sb_addr_out),
      .sb_wdata_out (sb_wdata_out),
      .sb_rdata_in  (sb_rdata_in),
      .sb_ack_in    (sb_ack_in),
      .sb_err_in    (sb_err_in)
   );

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);

   sequence s_wr_start;
      host_wr_in && is_data && !pending;
   endsequence
   sequence s_rd_start;
      host_rd_in && is_data && !pending;
   endsequence
   sequence s_rd_issue;
      sb_req_out && !sb_we_out && (sb_addr_out == $past(taddr_r));
   endsequence

   a_write_start_issue: // R02
   assert property (s_wr_start |=> sb_req_out && sb_we_out
                    && (sb_wdata_out == $past(host_wdata_in))
                    && (sb_addr_out == $past(taddr_r)))
      else $error("data write did not start a bus write");

   a_read_start_issue: // R03
   assert property (s_rd_start |=> s_rd_issue and (host_rdata_out == $past(tdata_r)))
      else $error("data read did not return held value and start read");

   a_read_result_load: // R03
   assert property (m_done && !m_err && m_read |=> tdata_r == $past(m_rdata))
      else $error("read result not loaded into transfer data");

   a_incr_step_four: // R04
   assert property (start && is_incr |=> taddr_r == $past(taddr_r) + SBIA_STEP)
      else $error("autoinc access did not step address by four");

   a_inert_no_access: // R05
   assert property ((host_rd_in || host_wr_in) && is_inrt && !pending |=> !sb_req_out)
      else $error("passive port started a bus access");

   a_error_marker_set: // R06
   assert property (m_done && m_err |=> err_r && (tdata_r == SBIA_MARKER))
      else $error("bus error did not set flag and marker");

   a_error_only_bus: // R07
   assert property ($rose(err_r) |-> $past(m_done && m_err))
      else $error("error flag rose without a bus error");

   a_busy_read_marker: // R08
   assert property (host_rd_in && port_hit && pending |=> host_rdata_out == SBIA_MARKER)
      else $error("data read while pending did not return marker");

   a_status_snapshot: // R09
   assert property (host_rd_in && port_hit ##1 host_rd_in && is_stat
                    |=> host_rdata_out[SBIA_ST_LRPND] == $past(pending, 2))
      else $error("last-read pending does not match state at data read");

   a_busy_no_step: // R13
   assert property (host_rd_in && is_incr && pending |=> taddr_r == $past(taddr_r))
      else $error("address stepped on a busy autoinc read");

   a_single_word_hold: // R01
   assert property (sb_req_out && !sb_ack_in |=> sb_req_out && $stable(sb_addr_out)
                    && $stable(sb_we_out))
      else $error("bus request dropped or changed before acknowledge");
endmodule // sbia_bridge

/* File: sbia_bridge_tb_top.sv */
`timescale 1ns/1ps
module sbia_bridge_tb_top;
   import sbia_pkg::*;
   logic        ref_clk_in, sys_rst_in, host_wr, host_rd, irq, sb_req, sb_we;
   logic        sb_ack, sb_err, bus_we, req_d;
   logic [2:0]  host_addr, lat;
   logic [31:0] host_wdata, host_rdata, sb_addr, sb_wdata, sb_rdata;
   logic [31:0] rd_v, st, base, bus_addr, bus_wd;
   logic [31:0] words [0:3];
   int          miscompares, total_checks, n_req, n0, tries;

   sbia_bridge dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .host_addr_in(host_addr),
      .host_wdata_in(host_wdata), .host_wr_in(host_wr), .host_rd_in(host_rd),
      .host_rdata_out(host_rdata), .sb_req_out(sb_req), .sb_we_out(sb_we),
      .sb_addr_out(sb_addr), .sb_wdata_out(sb_wdata), .sb_rdata_in(sb_rdata),
      .sb_ack_in(sb_ack), .sb_err_in(sb_err), .irq_out(irq));
   sbia_sb_model far (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .sb_req_in(sb_req),
      .sb_we_in(sb_we), .sb_addr_in(sb_addr), .sb_wdata_in(sb_wdata), .lat_in(lat),
      .sb_rdata_out(sb_rdata), .sb_ack_out(sb_ack), .sb_err_out(sb_err));

   // ---------------------------------------------------------------
   // clock and bus watcher
   // ---------------------------------------------------------------
   initial begin
      ref_clk_in = 1'b0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end
   // grab each new bus request so bus-side effects can be compared
   always @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         req_d <= 1'b0;
         n_req <= 0;
      end else begin
         req_d <= sb_req;
         if (sb_req && !req_d) begin
            n_req    <= n_req + 1;
            bus_addr <= sb_addr;
            bus_we   <= sb_we;
            bus_wd   <= sb_wdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // host port tasks
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [2:0] idx, input logic [31:0] d);
      @(posedge ref_clk_in);
      host_addr  <= idx;
      host_wdata <= d;
      host_wr    <= 1'b1;
      @(posedge ref_clk_in);
      host_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] idx, output logic [31:0] d);
      @(posedge ref_clk_in);
      host_addr <= idx;
      host_rd   <= 1'b1;
      @(posedge ref_clk_in);
      host_rd <= 1'b0;
      #1;
      d = host_rdata;
   endtask
   // two reads with no gap, so the second sees the first one's snapshot
   task automatic rd_pair(input logic [2:0] ia, input logic [2:0] ib,
                          output logic [31:0] da, output logic [31:0] db);
      @(posedge ref_clk_in);
      host_addr <= ia;
      host_rd   <= 1'b1;
      @(posedge ref_clk_in);
      host_addr <= ib;
      #1;
      da = host_rdata;
      @(posedge ref_clk_in);
      host_rd <= 1'b0;
      #1;
      db = host_rdata;
   endtask
   // bounded poll of the pending flag
   task automatic wait_idle;
      tries = 0;
      st    = 32'h1;
      while (st[SBIA_ST_PEND] !== 1'b0 && tries < 40) begin
         rd(SBIA_IDX_STAT, st);
         tries++;
      end
      chk("pending", 32'h0, {31'h0, st[SBIA_ST_PEND]});
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // watchdog and tests
   // ---------------------------------------------------------------
   initial begin
      #500000;
      miscompares++;
      finish_test();
   end
   initial begin
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_addr = 3'h0;
      host_wdata = 32'h0;
      lat = 3'h1;
      miscompares = 0;
      total_checks = 0;
      sys_rst_in = 1'b1;
      void'($urandom(91));
      repeat (6) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      rd(SBIA_IDX_STAT, rd_v);
      chk("status", 32'h0, rd_v);
      rd(3'h7, rd_v);
      chk("unmapped", 32'h0, rd_v);
      $display("test reset done");
      // single write; interrupt masked so irq must stay low
      base = 32'h40;
      for (int i = 0; i < 4; i++) words[i] = $urandom;
      wr(SBIA_IDX_ADDR, base);
      wr(SBIA_IDX_DATA, words[0]);
      wait_idle();
      chk("bus addr", base, bus_addr);
      chk("bus we", 32'h1, {31'h0, bus_we});
      chk("bus wdata", words[0], bus_wd);
      chk("irq masked", 32'h0, {31'h0, irq});
      rd(SBIA_IDX_IST, rd_v);
      chk("irq status", 32'h1, rd_v);
      wr(SBIA_IDX_IMSK, 32'h3);
      $display("test write done");
      // burst write through the stepping port at random bus waits
      wr(SBIA_IDX_ADDR, base);
      for (int i = 0; i < 4; i++) begin
         lat <= 3'($urandom_range(3));
         wr(SBIA_IDX_INCR, words[i]);
         wait_idle();
         chk("burst addr", base + 32'(4 * i), bus_addr);
         chk("burst wdata", words[i], bus_wd);
      end
      rd(SBIA_IDX_ADDR, rd_v);
      chk("addr step", base + 32'h10, rd_v);
      chk("irq done", 32'h1, {31'h0, irq});
      rd(SBIA_IDX_IST, rd_v);
      chk("irq clear", 32'h0, {31'h0, irq});
      $display("test burst done");
      // simple read, then passive port must never touch the bus
      wr(SBIA_IDX_ADDR, base + 32'h4);
      rd(SBIA_IDX_DATA, rd_v);
      wait_idle();
      n0 = n_req;
      rd(SBIA_IDX_INRT, rd_v);
      chk("simple read", words[1], rd_v);
      wr(SBIA_IDX_INRT, ~words[2]);
      rd(SBIA_IDX_INRT, rd_v);
      chk("passive data", ~words[2], rd_v);
      chk("bus idle", 32'(n0), 32'(n_req));
      $display("test simple read done");
      // optimized sequential read: slow bus forces busy answers
      lat <= 3'h5;
      wr(SBIA_IDX_ADDR, base);
      rd_pair(SBIA_IDX_INCR, SBIA_IDX_STAT, rd_v, st);
      chk("pair status", 32'h1, st);
      for (int i = 0; i < 4; i++) begin
         tries = 0;
         rd(SBIA_IDX_INCR, rd_v);
         while (rd_v === SBIA_MARKER && tries < 20) begin
            rd(SBIA_IDX_STAT, st);
            if (i == 0 && tries == 0) chk("busy flags", 32'h3, st & 32'h3);
            if (st[SBIA_ST_LRPND] === 1'b0) break;
            tries++;
            rd(SBIA_IDX_INCR, rd_v);
         end
         chk("opt word", words[i], rd_v);
      end
      wait_idle();
      rd(SBIA_IDX_ADDR, rd_v);
      chk("busy no step", base + 32'h14, rd_v);
      $display("test optimized read done");
      // error from an unpopulated region
      lat <= 3'h1;
      rd(SBIA_IDX_IST, rd_v);
      wr(SBIA_IDX_ADDR, 32'hE0000000);
      rd(SBIA_IDX_DATA, rd_v);
      wait_idle();
      rd(SBIA_IDX_INRT, rd_v);
      chk("error data", SBIA_MARKER, rd_v);
      rd(SBIA_IDX_STAT, rd_v);
      chk("error status", 32'hC, rd_v);
      chk("irq error", 32'h1, {31'h0, irq});
      rd(SBIA_IDX_IST, rd_v);
      chk("irq bits", 32'h3, rd_v);
      wr(SBIA_IDX_STAT, 32'h4);
      rd(SBIA_IDX_STAT, rd_v);
      chk("error clear", 32'h0, rd_v & 32'h4);
      $display("test error done");
      finish_test();
   end
endmodule // sbia_bridge_tb_top

/* File: sbia_master.sv */
`timescale 1ns/1ps
module sbia_master (
   input  wire logic        ref_clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        start_in,
   input  wire logic        we_in,
   input  wire logic [31:0] addr_in,
   input  wire logic [31:0] wdata_in,
   output logic             busy_out,
   output logic             done_out,
   output logic             err_out,
   output logic             read_out,
   output logic [31:0]      rdata_out,
   output logic             sb_req_out,
   output logic             sb_we_out,
   output logic [31:0]      sb_addr_out,
   output logic [31:0]      sb_wdata_out,
   input  wire logic [31:0] sb_rdata_in,
   input  wire logic        sb_ack_in,
   input  wire logic        sb_err_in
);
   import sbia_pkg::*;

   typedef enum logic [1:0] {
      SBIA_M_IDLE = 2'b01,
      SBIA_M_ACC  = 2'b10
   } sbia_mstate_t;

   sbia_mstate_t st_r, st_nxt;
   logic         req_r, req_nxt, we_r, we_nxt, done_r, done_nxt, err_r, err_nxt;
   logic [31:0]  addr_r, addr_nxt, wd_r, wd_nxt, rd_r, rd_nxt;

   // ---------------------------------------------------------------
   // one word per access, request held until the bus acknowledges
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt   = st_r;
      req_nxt  = req_r;
      we_nxt   = we_r;
      addr_nxt = addr_r;
      wd_nxt   = wd_r;
      rd_nxt   = rd_r;
      err_nxt  = err_r;
      done_nxt = 1'b0;
      case (st_r)
         SBIA_M_IDLE: begin
            if (start_in) begin
               st_nxt   = SBIA_M_ACC; // R01
               req_nxt  = 1'b1;
               we_nxt   = we_in;
               addr_nxt = addr_in;
               wd_nxt   = wdata_in;
            end
         end
         SBIA_M_ACC: begin
            if (sb_ack_in) begin
               st_nxt   = SBIA_M_IDLE;
               req_nxt  = 1'b0;
               done_nxt = 1'b1;
               err_nxt  = sb_err_in;
               rd_nxt   = sb_rdata_in;
            end
         end
         default: begin
            st_nxt  = SBIA_M_IDLE;
            req_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st_r   <= SBIA_M_IDLE;
         req_r  <= 1'b0;
         we_r   <= 1'b0;
         addr_r <= SBIA_RST_WORD;
         wd_r   <= SBIA_RST_WORD;
         rd_r   <= SBIA_RST_WORD;
         err_r  <= 1'b0;
         done_r <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         req_r  <= req_nxt;
         we_r   <= we_nxt;
         addr_r <= addr_nxt;
         wd_r   <= wd_nxt;
         rd_r   <= rd_nxt;
         err_r  <= err_nxt;
         done_r <= done_nxt;
      end
   end

   // busy covers the result cycle so no read sees stale data
   assign busy_out     = (st_r == SBIA_M_ACC) | done_r;
   assign done_out     = done_r;
   assign err_out      = err_r;
   assign read_out     = ~we_r;
   assign rdata_out    = rd_r;
   assign sb_req_out   = req_r;
   assign sb_we_out    = we_r;
   assign sb_addr_out  = addr_r;
   assign sb_wdata_out = wd_r;
endmodule // sbia_master

/* File: sbia_pkg.sv */
// Notes on behaviour
// R01: a private bus master issues every shared bus access, one 32-bit word each.
// R02: writing the transfer data register starts a bus write at the target address.
// R03: reading transfer data returns held value, starts bus read, result reloads it.
// R04: autoinc port acts as transfer data; target address advances four per access.
// R05: passive port reads and overwrites transfer data, never starts a bus access.
// R06: bus error sets the access error flag and loads transfer data with marker.
// R07: the bus flags errors only for missing regions or illegal registers; debug aid.
// R08: data port reads return the marker 0x88888888 while an access is pending.
// R09: status shows pending, plus pending and error state at the last data read.
// R10: host may read a data port right after a read; non-marker means valid.
// R11: on marker, host reads status; both last-read flags clear means genuine data.
// R12: last-read pending set means the read was incomplete; host repeats it.
// R13: autoinc reads answered while busy do not advance the target address.
// R14: simple read: set address, dummy read, wait not busy, fetch via passive port.
package sbia_pkg;
   // ---------------------------------------------------------------
   // register indices on the host port
   // ---------------------------------------------------------------
   localparam int          SBIA_IDX_W    = 3;
   localparam logic [2:0]  SBIA_IDX_STAT = 3'h0;
   localparam logic [2:0]  SBIA_IDX_ADDR = 3'h1;
   localparam logic [2:0]  SBIA_IDX_DATA = 3'h2;
   localparam logic [2:0]  SBIA_IDX_INCR = 3'h3;
   localparam logic [2:0]  SBIA_IDX_INRT = 3'h4;
   localparam logic [2:0]  SBIA_IDX_IST  = 3'h5;
   localparam logic [2:0]  SBIA_IDX_IMSK = 3'h6;
   // ---------------------------------------------------------------
   // status and interrupt field positions
   // ---------------------------------------------------------------
   localparam int          SBIA_ST_PEND  = 0;
   localparam int          SBIA_ST_LRPND = 1;
   localparam int          SBIA_ST_ERR   = 2;
   localparam int          SBIA_ST_LRERR = 3;
   localparam int          SBIA_IRQ_W    = 2;
   localparam int          SBIA_IRQ_DONE = 0;
   localparam int          SBIA_IRQ_ERR  = 1;
   // ---------------------------------------------------------------
   // values
   // ---------------------------------------------------------------
   localparam logic [31:0] SBIA_MARKER   = 32'h88888888;
   localparam logic [31:0] SBIA_STEP     = 32'h00000004;
   localparam logic [31:0] SBIA_RST_WORD = 32'h00000000;
   localparam logic [1:0]  SBIA_RST_IRQ  = 2'h0;
endpackage

/* File: sbia_sb_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// shared bus slave: small word memory with a settable wait
// ---------------------------------------------------------------
module sbia_sb_model (
   input  wire logic        ref_clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        sb_req_in,
   input  wire logic        sb_we_in,
   input  wire logic [31:0] sb_addr_in,
   input  wire logic [31:0] sb_wdata_in,
   input  wire logic [2:0]  lat_in,
   output logic      [31:0] sb_rdata_out,
   output logic             sb_ack_out,
   output logic             sb_err_out
);
   logic [31:0] mem [0:15];
   logic [2:0]  wait_cnt;
   logic        bad_addr;

   // only region 0xE is unpopulated, so only it answers with an error
   assign bad_addr = (sb_addr_in[31:28] == 4'hE);

   // one word per request; lat_in may only change while no request is up,
   // since a wait count already past it must wrap around before the bus answers
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wait_cnt     <= 3'h0;
         sb_ack_out   <= 1'b0;
         sb_err_out   <= 1'b0;
         sb_rdata_out <= 32'h5A5A5A5A;
      end else if (sb_req_in && !sb_ack_out && wait_cnt == lat_in) begin
         wait_cnt   <= 3'h0;
         sb_ack_out <= 1'b1;
         sb_err_out <= bad_addr;
         if (sb_we_in && !bad_addr) begin
            mem[sb_addr_in[5:2]] <= sb_wdata_in;
         end
         sb_rdata_out <= bad_addr ? ~sb_rdata_out : mem[sb_addr_in[5:2]];
      end else begin
         wait_cnt     <= (sb_req_in && !sb_ack_out) ? wait_cnt + 3'h1 : 3'h0;
         sb_ack_out   <= 1'b0;
         sb_err_out   <= 1'b0;
         sb_rdata_out <= ~sb_rdata_out; // data line not valid outside the answer
      end
   end
endmodule // sbia_sb_model
